// ### rtl/peer_link_cfg.svh
`ifndef PEER_LINK_CFG_SVH
`define PEER_LINK_CFG_SVH

// ==========================================================
// Clock and time base
`define CLK_PERIOD_NS     100
`define NS_PER_MS         1000000
`define CYC_PER_MS        (`NS_PER_MS / `CLK_PERIOD_NS)

// ==========================================================
// Timeout selection codes
`define TSEL_NONE         2'h0
`define TSEL_SHORT        2'h1
`define TSEL_MEDIUM       2'h2
`define TSEL_LONG         2'h3

// ==========================================================
// Timeouts in milliseconds
`define INQ_MS_SHORT      50
`define INQ_MS_MEDIUM     400
`define INQ_MS_LONG       800
`define HSTART_MS_SHORT   50
`define HSTART_MS_MEDIUM  400
`define HSTART_MS_LONG    800
`define HRX_MS            670
`define HACK_MS_SHORT     50
`define HACK_MS_MEDIUM    1000
`define HACK_MS_LONG      2000
`define TEXT_MS_SHORT     50
`define TEXT_MS_MEDIUM    10000
`define TEXT_MS_LONG      20000
`define BACK_MS_SHORT     50
`define BACK_MS_MEDIUM    10000
`define BACK_MS_LONG      20000
`define END_MS_SHORT      50
`define END_MS_MEDIUM     400
`define END_MS_LONG       800

// ==========================================================
// Retry limits
`define INQ_RETRY_MAX     6'h20
`define HEAD_RETRY_MAX    6'h03
`define BLK_RETRY_MAX     6'h03

// ==========================================================
// Register offsets
`define REG_CTRL          4'h0
`define REG_BLOCKS        4'h4
`define REG_STATUS        4'h8
`define REG_COUNTS        4'hC

// ==========================================================
// Field positions
`define CTRL_START_BIT    0
`define CTRL_READ_BIT     1
`define CTRL_TSEL_LO      2
`define CTRL_TSEL_HI      3
`define ST_STATE_LO       0
`define ST_STATE_HI       9
`define ST_BUSY_BIT       16
`define ST_BACKOFF_BIT    17
`define ST_DONE_BIT       18
`define ST_ABORT_BIT      19
`define ST_PEND_BIT       20
`define CNT_INQ_LO        0
`define CNT_INQ_HI        5
`define CNT_HEAD_LO       8
`define CNT_HEAD_HI       13
`define CNT_BLK_LO        16
`define CNT_BLK_HI        21

// ==========================================================
// Reset values
`define TSEL_RESET        `TSEL_LONG
`define BLOCKS_RESET      8'h01

`endif

// ### rtl/peer_link_pkg.sv
`default_nettype none
package peer_link_pkg;

  // Receive events, already classified by the character layer
  typedef enum logic [3:0] {
    RX_INQ       = 4'h0,
    RX_ACK       = 4'h1,
    RX_NAK       = 4'h2,
    RX_EOT       = 4'h3,
    RX_SOH       = 4'h4,
    RX_STX       = 4'h5,
    RX_CHAR      = 4'h6,
    RX_GOOD_HEAD = 4'h7,
    RX_BAD_HEAD  = 4'h8,
    RX_GOOD_DATA = 4'h9,
    RX_BAD_DATA  = 4'hA
  } rx_kind_t;

  typedef enum logic [2:0] {
    TX_INQ    = 3'h0,
    TX_ACK    = 3'h1,
    TX_NAK    = 3'h2,
    TX_EOT    = 3'h3,
    TX_HEADER = 3'h4,
    TX_BLOCK  = 3'h5
  } tx_kind_t;

  typedef enum logic [2:0] {
    TM_INQ    = 3'h0,
    TM_HSTART = 3'h1,
    TM_HRX    = 3'h2,
    TM_HACK   = 3'h3,
    TM_TEXT   = 3'h4,
    TM_BACK   = 3'h5,
    TM_END    = 3'h6
  } timer_kind_t;

  typedef enum logic [9:0] {
    ST_IDLE       = 10'h001,
    ST_INQ_ACK    = 10'h002,
    ST_HEAD_START = 10'h004,
    ST_HEAD_RX    = 10'h008,
    ST_HEAD_ACK   = 10'h010,
    ST_BLOCK_ACK  = 10'h020,
    ST_TEXT_WAIT  = 10'h040,
    ST_BLOCK_RX   = 10'h080,
    ST_END_WAIT   = 10'h100,
    ST_COLLISION  = 10'h200
  } state_t;

endpackage
`default_nettype wire

// ### rtl/peer_timer.sv
`default_nettype none
module peer_timer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Control
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [31:0] load,
  // Status
  output logic             expired
);

  logic [31:0] count;
  logic        armed;

  // ==========================================================
  // Down-counter, reloaded on every start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count   <= 32'h0000_0000;
      armed   <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        // A zero load means no timeout at all
        count <= load;
        armed <= (load != 32'h0000_0000);
      end else if (stop) begin
        armed <= 1'b0;
      end else if (armed) begin
        if (count == 32'h0000_0001) begin
          armed   <= 1'b0;
          expired <= 1'b1;
        end else begin
          count <= count - 32'h0000_0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/peer_link_transfer_fsm.sv
// Function
// - request in idle sends inquiry, waits acknowledge
// - inquiry in idle acknowledged, await heading start
// - inquiry during own inquiry sets backoff, collision
// - inquiry retried up to 33, else end
// - inquiry acknowledged sends header, awaits acknowledge
// - refused header retried up to 4, else end
// - header acknowledged: read waits text, write sends
// - heading start received starts header reception
// - good header acknowledged, then read or write
// - bad header refused up to 4, else end
// - good block delivered, acknowledged, then wait
// - bad block refused up to 4, else end
// - refused sent block retried up to 4
// - unexpected event outside idle, or timeout outside inquiry wait, ends with end-of-transmission
// - expired timeout outside inquiry wait aborts and sends end-of-transmission
// - inquiry wait defaults 800, also 400, 50, none
// - no retry once end-of-transmission received
//
// Chosen here: the address-and-strobe port and the register addresses.
`include "peer_link_cfg.svh"
`default_nettype none
module peer_link_transfer_fsm #(
  parameter int unsigned CYC_PER_MS = `CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // Software register port
  input  wire logic [3:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_write,
  input  wire logic                     reg_read,
  output logic      [31:0]              reg_rdata,
  // Received events from the link
  input  wire logic                     rx_valid,
  input  wire peer_link_pkg::rx_kind_t  rx_kind,
  input  wire logic                     rx_head_read,
  input  wire logic                     rx_last,
  // Transmit requests to the link
  output logic                          tx_valid,
  output peer_link_pkg::tx_kind_t       tx_kind,
  output logic                          tx_head_read,
  output logic      [7:0]               tx_head_blocks,
  output logic      [7:0]               tx_block_index,
  // Local data
  output logic                          fetch_req,
  input  wire logic                     local_valid,
  output logic                          deliver
);
  import peer_link_pkg::*;

  state_t      state;
  state_t      next_state;
  logic        start_pend;
  logic        dir_read;
  logic [1:0]  tsel;
  logic [7:0]  blocks;
  logic        backoff;
  logic        done;
  logic        aborted;
  logic        blk_pending;
  logic [5:0]  inq_cnt;
  logic [5:0]  head_cnt;
  logic [5:0]  blk_cnt;
  logic        expired;
  logic [31:0] t_load;
  // Decisions of the transition logic
  logic        send;
  tx_kind_t    send_kind;
  logic        t_start;
  logic        t_stop;
  timer_kind_t t_kind;
  logic        clr_all;
  logic        inc_inq;
  logic        inc_head;
  logic        inc_blk;
  logic        clr_blk;
  logic        fetch;
  logic        give;
  logic        take_req;
  logic        set_backoff;
  logic        fin_ok;
  logic        fin_abort;
  logic        block_done;
  logic        last_sent;

  // ==========================================================
  // Timeout table
  function automatic int unsigned timeout_ms(timer_kind_t k, logic [1:0] s);
    int unsigned ms;
    ms = 0;
    if (s != `TSEL_NONE) begin
      unique case (k)
        TM_INQ:    ms = (s == `TSEL_SHORT) ? `INQ_MS_SHORT :
                        (s == `TSEL_MEDIUM) ? `INQ_MS_MEDIUM : `INQ_MS_LONG;
        TM_HSTART: ms = (s == `TSEL_SHORT) ? `HSTART_MS_SHORT :
                        (s == `TSEL_MEDIUM) ? `HSTART_MS_MEDIUM : `HSTART_MS_LONG;
        TM_HRX:    ms = `HRX_MS;
        TM_HACK:   ms = (s == `TSEL_SHORT) ? `HACK_MS_SHORT :
                        (s == `TSEL_MEDIUM) ? `HACK_MS_MEDIUM : `HACK_MS_LONG;
        TM_TEXT:   ms = (s == `TSEL_SHORT) ? `TEXT_MS_SHORT :
                        (s == `TSEL_MEDIUM) ? `TEXT_MS_MEDIUM : `TEXT_MS_LONG;
        TM_BACK:   ms = (s == `TSEL_SHORT) ? `BACK_MS_SHORT :
                        (s == `TSEL_MEDIUM) ? `BACK_MS_MEDIUM : `BACK_MS_LONG;
        TM_END:    ms = (s == `TSEL_SHORT) ? `END_MS_SHORT :
                        (s == `TSEL_MEDIUM) ? `END_MS_MEDIUM : `END_MS_LONG;
        default:   ms = 0;
      endcase
    end
    return ms;
  endfunction

  assign t_load = 32'(timeout_ms(t_kind, tsel) * CYC_PER_MS);

  peer_timer u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (t_start),
    .stop    (t_stop),
    .load    (t_load),
    .expired (expired)
  );

  assign last_sent = (tx_block_index == 8'(blocks - 8'h01));

  // ==========================================================
  // Transition logic
  always_comb begin
    next_state  = state;
    send        = 1'b0;
    send_kind   = TX_EOT;
    t_start     = 1'b0;
    t_stop      = 1'b0;
    t_kind      = TM_INQ;
    clr_all     = 1'b0;
    inc_inq     = 1'b0;
    inc_head    = 1'b0;
    inc_blk     = 1'b0;
    clr_blk     = 1'b0;
    fetch       = 1'b0;
    give        = 1'b0;
    take_req    = 1'b0;
    set_backoff = 1'b0;
    fin_ok      = 1'b0;
    fin_abort   = 1'b0;
    block_done  = 1'b0;
    if (state != ST_IDLE && rx_valid && rx_kind == RX_EOT) begin
      // Quiet return; nothing is retried after the far end ends
      next_state = ST_IDLE;
      t_stop     = 1'b1;
      fin_ok     = (state == ST_END_WAIT);
      fin_abort  = (state != ST_END_WAIT);
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (rx_valid && rx_kind == RX_INQ) begin
            clr_all = 1'b1;
            send = 1'b1; send_kind = TX_ACK;
            t_start = 1'b1; t_kind = TM_HSTART;
            next_state = ST_HEAD_START;
          end else if (start_pend) begin
            take_req = 1'b1;
            clr_all = 1'b1;
            send = 1'b1; send_kind = TX_INQ;
            t_start = 1'b1; t_kind = TM_INQ;
            next_state = ST_INQ_ACK;
          end
        end
        ST_INQ_ACK, ST_COLLISION: begin
          if (rx_valid && rx_kind == RX_INQ && state == ST_INQ_ACK) begin
            set_backoff = 1'b1;
            next_state = ST_COLLISION;
          end else if (rx_valid && rx_kind == RX_INQ) begin
            clr_all = 1'b1;
            send = 1'b1; send_kind = TX_ACK;
            t_start = 1'b1; t_kind = TM_HSTART;
            next_state = ST_HEAD_START;
          end else if (rx_valid && rx_kind == RX_ACK) begin
            send = 1'b1; send_kind = TX_HEADER;
            t_start = 1'b1; t_kind = TM_HACK;
            next_state = ST_HEAD_ACK;
          end else if ((rx_valid && rx_kind == RX_NAK) || expired) begin
            if (inq_cnt <= `INQ_RETRY_MAX) begin
              inc_inq = 1'b1;
              send = 1'b1; send_kind = TX_INQ;
              t_start = 1'b1; t_kind = TM_INQ;
              next_state = ST_INQ_ACK;
            end else begin
              send = 1'b1; next_state = ST_IDLE; fin_abort = 1'b1;
            end
          end else if (rx_valid) begin
            send = 1'b1; next_state = ST_IDLE; fin_abort = 1'b1;
            t_stop = 1'b1;
          end
        end
        ST_HEAD_START: begin
          if (rx_valid && rx_kind == RX_SOH) begin
            t_start = 1'b1; t_kind = TM_HRX;
            next_state = ST_HEAD_RX;
          end else if (rx_valid || expired) begin
            send = 1'b1; next_state = ST_IDLE; fin_abort = 1'b1;
            t_stop = 1'b1;
          end
        end
        ST_HEAD_RX: begin
          if (rx_valid && rx_kind == RX_GOOD_HEAD) begin
            send = 1'b1; send_kind = TX_ACK;
            if (rx_head_read) begin
              t_start = 1'b1; t_kind = TM_TEXT;
              next_state = ST_TEXT_WAIT;
            end else begin
              t_stop = 1'b1; fetch = 1'b1;
              next_state = ST_BLOCK_ACK;
            end
          end else if (rx_valid && rx_kind == RX_BAD_HEAD && head_cnt <= `HEAD_RETRY_MAX) begin
            inc_head = 1'b1;
            send = 1'b1; send_kind = TX_NAK;
            t_start = 1'b1; t_kind = TM_HSTART;
            next_state = ST_HEAD_START;
          end else if (rx_valid || expired) begin
            send = 1'b1; next_state = ST_IDLE; fin_abort = 1'b1;
            t_stop = 1'b1;
          end
        end
        ST_HEAD_ACK: begin
          if (rx_valid && rx_kind == RX_ACK) begin
            if (dir_read) begin
              t_start = 1'b1; t_kind = TM_TEXT;
              next_state = ST_TEXT_WAIT;
            end else begin
              t_stop = 1'b1; fetch = 1'b1;
              next_state = ST_BLOCK_ACK;
            end
          end else if (rx_valid && rx_kind == RX_NAK && head_cnt <= `HEAD_RETRY_MAX) begin
            inc_head = 1'b1;
            send = 1'b1; send_kind = TX_HEADER;
            t_start = 1'b1; t_kind = TM_HACK;
          end else if (rx_valid || expired) begin
            send = 1'b1; next_state = ST_IDLE; fin_abort = 1'b1;
            t_stop = 1'b1;
          end
        end
        ST_BLOCK_ACK: begin
          if (blk_pending) begin
            // Waiting on local data; the link is quiet meanwhile
            if (local_valid) begin
              clr_blk = 1'b1;
              send = 1'b1; send_kind = TX_BLOCK;
              t_start = 1'b1; t_kind = TM_BACK;
            end else if (rx_valid) begin
              send = 1'b1; next_state = ST_IDLE; fin_abort = 1'b1;
            end
          end else if (rx_valid && rx_kind == RX_ACK) begin
            t_stop = 1'b1;
            if (last_sent) begin
              send = 1'b1; next_state = ST_IDLE; fin_ok = 1'b1;
            end else begin
              block_done = 1'b1; fetch = 1'b1;
            end
          end else if (rx_valid && rx_kind == RX_NAK && blk_cnt <= `BLK_RETRY_MAX) begin
            inc_blk = 1'b1;
            send = 1'b1; send_kind = TX_BLOCK;
            t_start = 1'b1; t_kind = TM_BACK;
          end else if (rx_valid || expired) begin
            send = 1'b1; next_state = ST_IDLE; fin_abort = 1'b1;
            t_stop = 1'b1;
          end
        end
        ST_TEXT_WAIT: begin
          if (rx_valid && rx_kind == RX_STX) begin
            t_start = 1'b1; t_kind = TM_HRX;
            next_state = ST_BLOCK_RX;
          end else if (rx_valid || expired) begin
            send = 1'b1; next_state = ST_IDLE; fin_abort = 1'b1;
            t_stop = 1'b1;
          end
        end
        ST_BLOCK_RX: begin
          if (rx_valid && rx_kind == RX_GOOD_DATA) begin
            give = 1'b1;
            send = 1'b1; send_kind = TX_ACK;
            t_start = 1'b1;
            t_kind = rx_last ? TM_END : TM_TEXT;
            next_state = rx_last ? ST_END_WAIT : ST_TEXT_WAIT;
          end else if (rx_valid && rx_kind == RX_BAD_DATA && blk_cnt <= `BLK_RETRY_MAX) begin
            inc_blk = 1'b1;
            send = 1'b1; send_kind = TX_NAK;
            t_start = 1'b1; t_kind = TM_TEXT;
            next_state = ST_TEXT_WAIT;
          end else if (rx_valid || expired) begin
            send = 1'b1; next_state = ST_IDLE; fin_abort = 1'b1;
            t_stop = 1'b1;
          end
        end
        ST_END_WAIT: begin
          if (rx_valid || expired) begin
            send = 1'b1; next_state = ST_IDLE; fin_abort = 1'b1;
            t_stop = 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // State
  always_ff @(posedge clk) begin
    if (sys_rst) state <= ST_IDLE;
    else         state <= next_state;
  end

  // ==========================================================
  // Retry counters
  always_ff @(posedge clk) begin
    if (sys_rst || clr_all) begin
      inq_cnt  <= 6'h00;
      head_cnt <= 6'h00;
      blk_cnt  <= 6'h00;
    end else begin
      if (inc_inq)  inq_cnt  <= inq_cnt + 6'h01;
      if (inc_head) head_cnt <= head_cnt + 6'h01;
      if (clr_blk)  blk_cnt  <= 6'h00;
      else if (inc_blk) blk_cnt <= blk_cnt + 6'h01;
    end
  end

  // ==========================================================
  // Block sequencing and local data handshake
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blk_pending    <= 1'b0;
      tx_block_index <= 8'h00;
      fetch_req      <= 1'b0;
      deliver        <= 1'b0;
    end else begin
      fetch_req <= fetch;
      deliver   <= give;
      if (clr_all)                blk_pending <= 1'b0;
      else if (fetch)             blk_pending <= 1'b1;
      else if (next_state == ST_IDLE) blk_pending <= 1'b0;
      else if (local_valid)       blk_pending <= 1'b0;
      if (clr_all)         tx_block_index <= 8'h00;
      else if (block_done) tx_block_index <= tx_block_index + 8'h01;
    end
  end

  // ==========================================================
  // Transmit request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_valid <= 1'b0;
      tx_kind  <= TX_EOT;
    end else begin
      tx_valid <= send;
      if (send) tx_kind <= send_kind;
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_pend <= 1'b0;
      dir_read   <= 1'b0;
      tsel       <= `TSEL_RESET;
      blocks     <= `BLOCKS_RESET;
    end else begin
      // Direction and blocks stay frozen while busy; header content must not move
      if (reg_write && reg_addr == `REG_CTRL && state == ST_IDLE) begin
        dir_read <= reg_wdata[`CTRL_READ_BIT];
        tsel     <= reg_wdata[`CTRL_TSEL_HI:`CTRL_TSEL_LO];
      end
      if (reg_write && reg_addr == `REG_BLOCKS && state == ST_IDLE) blocks <= reg_wdata[7:0];
      if (reg_write && reg_addr == `REG_CTRL && reg_wdata[`CTRL_START_BIT]) start_pend <= 1'b1;
      else if (take_req) start_pend <= 1'b0;
    end
  end

  assign tx_head_read   = dir_read;
  assign tx_head_blocks = blocks;

  // ==========================================================
  // Status flags; a finish in the cycle of a start write still sets
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      backoff <= 1'b0;
      done    <= 1'b0;
      aborted <= 1'b0;
    end else begin
      if (set_backoff)   backoff <= 1'b1;
      else if (take_req) backoff <= 1'b0;
      if (fin_ok)        done <= 1'b1;
      else if (take_req) done <= 1'b0;
      if (fin_abort)     aborted <= 1'b1;
      else if (take_req) aborted <= 1'b0;
    end
  end

  // ==========================================================
  // Read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_read) begin
        unique case (reg_addr)
          `REG_CTRL: begin
            reg_rdata[`CTRL_READ_BIT]                <= dir_read;
            reg_rdata[`CTRL_TSEL_HI:`CTRL_TSEL_LO]   <= tsel;
          end
          `REG_BLOCKS: reg_rdata[7:0] <= blocks;
          `REG_STATUS: begin
            reg_rdata[`ST_STATE_HI:`ST_STATE_LO] <= state;
            reg_rdata[`ST_BUSY_BIT]              <= (state != ST_IDLE);
            reg_rdata[`ST_BACKOFF_BIT]           <= backoff;
            reg_rdata[`ST_DONE_BIT]              <= done;
            reg_rdata[`ST_ABORT_BIT]             <= aborted;
            reg_rdata[`ST_PEND_BIT]              <= start_pend;
          end
          `REG_COUNTS: begin
            reg_rdata[`CNT_INQ_HI:`CNT_INQ_LO]   <= inq_cnt;
            reg_rdata[`CNT_HEAD_HI:`CNT_HEAD_LO] <= head_cnt;
            reg_rdata[`CNT_BLK_HI:`CNT_BLK_LO]   <= blk_cnt;
          end
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ### tb/peer_far_model.sv
`default_nettype none
module peer_far_model
  import peer_link_pkg::*;
(
  // Bench control
  input  wire logic                clk,
  input  wire logic                auto_en,
  input  var  peer_link_pkg::rx_kind_t auto_kind,
  input  wire logic                inj,
  input  var  peer_link_pkg::rx_kind_t inj_kind,
  // Link
  input  wire logic                tx_valid,
  input  var  peer_link_pkg::tx_kind_t tx_kind,
  input  wire logic                fetch_req,
  output logic                     rx_valid,
  output peer_link_pkg::rx_kind_t  rx_kind,
  output logic                     local_valid
);
  import peer_link_pkg::*;
  logic [1:0] wait_cnt = 2'h0;
  // ==========================================================
  // Replies come late, as over a real line
  always_ff @(posedge clk) begin
    if (tx_valid && auto_en && tx_kind inside {TX_INQ, TX_HEADER, TX_BLOCK}) begin
      wait_cnt <= 2'h3;
    end else if (wait_cnt != 2'h0) begin
      wait_cnt <= wait_cnt - 2'h1;
    end
  end
  always_ff @(posedge clk) begin
    rx_valid <= inj || wait_cnt == 2'h1;
    rx_kind  <= inj ? inj_kind : auto_kind;
  end
  always_ff @(posedge clk) local_valid <= fetch_req;
endmodule
`default_nettype wire

// ### tb/peer_link_transfer_fsm_properties.sv
`default_nettype none
module peer_link_transfer_fsm_properties
  import peer_link_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = 10000
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic        rx_valid,
  input var  peer_link_pkg::rx_kind_t rx_kind,
  input wire logic        tx_valid,
  input var  peer_link_pkg::tx_kind_t tx_kind,
  input wire logic        fetch_req,
  input wire logic        local_valid,
  input wire logic        deliver
);
  import peer_link_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence rx_is(rx_kind_t k);
    rx_valid && rx_kind == k;
  endsequence
  a_rst_quiet: assert property ($fell(sys_rst) |-> !tx_valid && !deliver && !fetch_req)
    else $error("output active after reset");
  a_eot_silent: assert property (rx_is(RX_EOT) |=> !tx_valid)
    else $error("reply to end of transmission");
  a_char_ends: assert property (rx_is(RX_CHAR) |=> !tx_valid || tx_kind == TX_EOT)
    else $error("stray character not ended");
  a_inq_reply: assert property (rx_is(RX_INQ) |=> !tx_valid || tx_kind inside {TX_ACK, TX_EOT})
    else $error("bad reply to inquiry");
  a_nak_reply: assert property (rx_is(RX_NAK) |=> !tx_valid || tx_kind != TX_ACK)
    else $error("refusal acknowledged");
  a_stx_silent: assert property (rx_is(RX_STX) |=> !tx_valid || tx_kind == TX_EOT)
    else $error("bad reply to text start");
  a_fetch_block: assert property (fetch_req ##1 (local_valid && !rx_valid) |=>
    tx_valid && tx_kind == TX_BLOCK)
    else $error("local data not sent");
  a_deliver_ack: assert property (rx_is(RX_GOOD_DATA) ##1 deliver |-> tx_valid && tx_kind == TX_ACK)
    else $error("delivered block not acknowledged");
  a_rdata_zero: assert property (!reg_read |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule
bind peer_link_transfer_fsm peer_link_transfer_fsm_properties #(.CYC_PER_MS(CYC_PER_MS)) props_i (
  .clk, .sys_rst, .reg_read, .reg_rdata, .rx_valid, .rx_kind, .tx_valid, .tx_kind,
  .fetch_req, .local_valid, .deliver);
`default_nettype wire

// ### tb/peer_link_transfer_fsm_tb.sv
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module peer_link_transfer_fsm_tb
  import peer_link_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, sys_rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, inj = 1'b0;
  logic        rx_head_read = 1'b0, rx_last = 1'b0, auto_en = 1'b0;
  logic        rx_valid, tx_valid, tx_head_read, fetch_req, local_valid, deliver;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
  logic [7:0]  tx_head_blocks, tx_block_index;
  rx_kind_t    auto_kind = RX_ACK, inj_kind = RX_ACK, rx_kind;
  tx_kind_t    tx_kind;
  tx_kind_t    txq[$];
  int          n_fail = 0, cmp_count = 0, n_del = 0, i;
  // Short millisecond keeps the 50 ms timeouts at 500 cycles
  peer_link_transfer_fsm #(.CYC_PER_MS(10)) peer_link_transfer_fsm_i (.clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .rx_valid, .rx_kind, .rx_head_read,
    .rx_last, .tx_valid, .tx_kind, .tx_head_read, .tx_head_blocks, .tx_block_index,
    .fetch_req, .local_valid, .deliver);
  peer_far_model peer_far_model_i (.clk, .auto_en, .auto_kind, .inj, .inj_kind, .tx_valid,
    .tx_kind, .fetch_req, .rx_valid, .rx_kind, .local_valid);
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    if (tx_valid) txq.push_back(tx_kind);
    if (deliver) n_del++;
  end
  // ==========================================================
  // Access tasks
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic ev(input rx_kind_t k);
    @(posedge clk);
    inj <= 1'b1;
    inj_kind <= k;
    @(posedge clk);
    inj <= 1'b0;
  endtask
  task automatic wn(input int n);
    for (int j = 0; j < 900 && txq.size() < n; j++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task automatic cq(input tx_kind_t e[$]);
    `CHK(txq.size(), e.size())
    foreach (e[j]) `CHK(txq[j], e[j])
    txq.delete();
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(4'h0, v); `CHK(v, 32'h0000000C)
    rd(4'h8, v); `CHK(v, 32'h00000001)
    rd(4'hC, v); `CHK(v, 32'h00000000)
    rd(4'h3, v); `CHK(v, 32'h00000000)
    $display("test reset done");
    auto_en <= 1'b1;
    wr(4'h0, 32'h00000005);
    wn(4);
    cq('{TX_INQ, TX_HEADER, TX_BLOCK, TX_EOT});
    `CHK(tx_head_blocks, 8'h01)
    rd(4'h8, v); `CHK(v, 32'h00040001)
    $display("test write done");
    wr(4'h4, 32'h00000002);
    wr(4'h0, 32'h00000005);
    wn(5);
    cq('{TX_INQ, TX_HEADER, TX_BLOCK, TX_BLOCK, TX_EOT});
    `CHK(tx_block_index, 8'h01)
    `CHK(tx_head_blocks, 8'h02)
    $display("test blocks done");
    auto_kind <= RX_NAK;
    wr(4'h0, 32'h00000005);
    wn(35);
    `CHK(txq[33], TX_INQ)
    `CHK(txq.size(), 35)
    `CHK(txq[0], TX_INQ)
    `CHK(txq[34], TX_EOT)
    txq.delete();
    rd(4'hC, v); `CHK(v, 32'h00000021)
    rd(4'h8, v); `CHK(v, 32'h00080001)
    $display("test retry done");
    auto_en <= 1'b0;
    ev(RX_INQ);
    ev(RX_SOH);
    rx_head_read <= 1'b1;
    ev(RX_GOOD_HEAD);
    ev(RX_STX);
    ev(RX_BAD_DATA);
    ev(RX_STX);
    rx_last <= 1'b1;
    ev(RX_GOOD_DATA);
    ev(RX_EOT);
    wn(4);
    cq('{TX_ACK, TX_ACK, TX_NAK, TX_ACK});
    `CHK(n_del, 1)
    rd(4'hC, v); `CHK(v, 32'h00010000)
    $display("test receive done");
    wr(4'h0, 32'h00000007);
    wn(1);
    ev(RX_INQ);
    rd(4'h8, v); `CHK(v & 32'h000203FF, 32'h00020200)
    ev(RX_ACK);
    ev(RX_CHAR);
    wn(3);
    cq('{TX_INQ, TX_HEADER, TX_EOT});
    `CHK(tx_head_read, 1'b1)
    $display("test collision done");
    ev(RX_INQ);
    wn(1);
    for (i = 0; i < 700 && txq.size() < 2; i++) @(posedge clk);
    `CHK(i > 480 && i < 520, 1'b1)
    cq('{TX_ACK, TX_EOT});
    $display("test timeout done");
    end_sim;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    end_sim;
  end
endmodule
`default_nettype wire
